// [verilog/ditc_pkg.sv]
// Constants, register map and carrier types for the input terminal conditioner.
// Assumes one 100 MHz core clock and an AHB-Lite register port with 32-bit data.
// Notes on behaviour
// - Nine-bit polarity mask, reset zero; a one makes that terminal active low.
// - All nine inputs pass a sampling filter, default 10 ms, up to 50 s.
// - Nine-bit virtual select: bits 0-7 general inputs, bit 8 high-speed input.
// - Inputs five to eight have no pin; their state comes from virtual bits, or from the polarity bit when not selected.
// - Two-bit control scheme field, range 0 to 3, reset 0 selects two-wire combined.
// - Scheme 0: both off stops, forward alone runs forward, backward alone reverse.
// - Scheme 1: forward input enables running, backward input picks direction.
// - Three-wire: enable closed, forward rising edge starts, direction from backward.
// - Three-wire enable must stay closed while running; opening it stops the drive.
package ditc_pkg;
    localparam int NUM_TERM = 9;
    localparam int TIME_W = 16;
    // Times are held in milliseconds; one millisecond is this many cycles.
    localparam int CLK_MHZ = 100;
    localparam int MS_CYCLES = CLK_MHZ * 1000;
    localparam logic [TIME_W-1:0] FILTER_MS_RST = 16'h000A;
    localparam logic [TIME_W-1:0] TIME_MS_MAX = 16'hC350;
    localparam logic [TIME_W-1:0] DELAY_MS_RST = 16'h0000;
    localparam logic [8:0] POLARITY_RST = 9'h000;
    localparam logic [8:0] VIRTUAL_RST = 9'h000;
    localparam logic [1:0] SCHEME_RST = 2'h0;
    // Byte offsets on the register bus.
    localparam logic [7:0] OFS_POLARITY = 8'h00;
    localparam logic [7:0] OFS_FILTER = 8'h04;
    localparam logic [7:0] OFS_VIRTUAL = 8'h08;
    localparam logic [7:0] OFS_SCHEME = 8'h0C;
    localparam logic [7:0] OFS_VSTATE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_DELAY_BASE = 8'h40;
    // Control scheme codes.
    localparam logic [1:0] SCH_TWO_COMB = 2'h0;
    localparam logic [1:0] SCH_TWO_SPLIT = 2'h1;
    // Terminal index of the command inputs.
    localparam int FWD_IDX = 0;
    localparam int BWD_IDX = 1;
    localparam int EN3_IDX = 2;
    // Status bit positions.
    localparam int ST_RUN_BIT = 9;
    localparam int ST_REV_BIT = 10;
    typedef struct packed {
        logic run;
        logic reverse;
    } ditc_cmd_t;
endpackage : ditc_pkg

// [verilog/ditc_conditioner.sv]
// Input terminal conditioner: filter, polarity, virtual substitution, delays, run decode.
// Assumes one AHB-Lite master as the only bus agent and pins synchronous to core_clk.
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module ditc_conditioner #(
    parameter int MS_CYC = ditc_pkg::MS_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Physical terminals: general inputs one to four and the high-speed input.
    input wire logic [3:0] generalInputsOneToFour,
    input wire logic highSpeedInput,
    // Conditioned states and decoded command.
    output logic [8:0] terminalState,
    output ditc_pkg::ditc_cmd_t runCmd
);
    localparam int N = ditc_pkg::NUM_TERM;
    localparam int TW = ditc_pkg::TIME_W;
    // 50 s at 100 MHz is five billion cycles, which overflows 32 bits.
    localparam int CW = 40;

    ////////////////////////////////////////////////////////////////////////////
    // Register file and bus slave.
    logic [8:0] polarity_ff, nxt_polarity;
    logic [8:0] virtSel_ff, nxt_virtSel;
    logic [8:0] virtState_ff, nxt_virtState;
    logic [1:0] scheme_ff, nxt_scheme;
    logic [TW-1:0] filterMs_ff, nxt_filterMs;
    logic [TW-1:0] onMs_ff [N];
    logic [TW-1:0] offMs_ff [N];
    logic [TW-1:0] nxt_onMs [N];
    logic [TW-1:0] nxt_offMs [N];
    logic wrPend_ff, nxt_wrPend;
    logic [7:0] wrAddr_ff, nxt_wrAddr;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [8:0] filtered;
    logic [8:0] cond_ff;
    ditc_pkg::ditc_cmd_t cmd_ff, nxt_cmd;

    // Writes complete in the data phase; reads are captured at the address phase.
    always_comb begin
        logic [7:0] a;
        logic [TW-1:0] t;
        logic [4:0] wIdx;
        logic [4:0] rIdx;
        a = haddr[7:0];
        // Terminal index of a delay pair, counted from the start of the delay block.
        wIdx = wrAddr_ff[7:3] - ditc_pkg::OFS_DELAY_BASE[7:3];
        rIdx = a[7:3] - ditc_pkg::OFS_DELAY_BASE[7:3];
        t = hwdata[TW-1:0] > ditc_pkg::TIME_MS_MAX ? ditc_pkg::TIME_MS_MAX : hwdata[TW-1:0];
        nxt_polarity = polarity_ff;
        nxt_virtSel = virtSel_ff;
        nxt_virtState = virtState_ff;
        nxt_scheme = scheme_ff;
        nxt_filterMs = filterMs_ff;
        nxt_onMs = onMs_ff;
        nxt_offMs = offMs_ff;
        nxt_wrPend = hsel && hready && htrans[1] && hwrite;
        nxt_wrAddr = a;
        nxt_rdata = rdata_ff;
        if (wrPend_ff) begin
            case (wrAddr_ff)
                ditc_pkg::OFS_POLARITY: nxt_polarity = hwdata[8:0];
                ditc_pkg::OFS_FILTER: nxt_filterMs = t;
                ditc_pkg::OFS_VIRTUAL: nxt_virtSel = hwdata[8:0];
                ditc_pkg::OFS_SCHEME: nxt_scheme = hwdata[1:0];
                ditc_pkg::OFS_VSTATE: nxt_virtState = hwdata[8:0];
                default: begin
                    // Delay pairs: on delay at even word, off delay at odd word.
                    if (wrAddr_ff >= ditc_pkg::OFS_DELAY_BASE && wrAddr_ff[7:3] < 5'(8 + N)) begin
                        if (wrAddr_ff[2]) begin
                            nxt_offMs[wIdx[3:0]] = t;
                        end else begin
                            nxt_onMs[wIdx[3:0]] = t;
                        end
                    end
                end
            endcase
        end
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (a)
                ditc_pkg::OFS_POLARITY: nxt_rdata = {23'h000000, polarity_ff};
                ditc_pkg::OFS_FILTER: nxt_rdata = {16'h0000, filterMs_ff};
                ditc_pkg::OFS_VIRTUAL: nxt_rdata = {23'h000000, virtSel_ff};
                ditc_pkg::OFS_SCHEME: nxt_rdata = {30'h00000000, scheme_ff};
                ditc_pkg::OFS_VSTATE: nxt_rdata = {23'h000000, virtState_ff};
                ditc_pkg::OFS_STATUS: nxt_rdata = {21'h000000, cmd_ff.reverse, cmd_ff.run, cond_ff};
                default: begin
                    nxt_rdata = 32'h00000000;
                    if (a >= ditc_pkg::OFS_DELAY_BASE && a[7:3] < 5'(8 + N)) begin
                        nxt_rdata = {16'h0000, a[2] ? offMs_ff[rIdx[3:0]] : onMs_ff[rIdx[3:0]]};
                    end
                end
            endcase
        end
    end

    // Register storage.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            polarity_ff <= ditc_pkg::POLARITY_RST;
            virtSel_ff <= ditc_pkg::VIRTUAL_RST;
            virtState_ff <= ditc_pkg::VIRTUAL_RST;
            scheme_ff <= ditc_pkg::SCHEME_RST;
            filterMs_ff <= ditc_pkg::FILTER_MS_RST;
            for (int i = 0; i < N; i++) begin
                onMs_ff[i] <= ditc_pkg::DELAY_MS_RST;
                offMs_ff[i] <= ditc_pkg::DELAY_MS_RST;
            end
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
            rdata_ff <= 32'h00000000;
        end else begin
            polarity_ff <= nxt_polarity;
            virtSel_ff <= nxt_virtSel;
            virtState_ff <= nxt_virtState;
            scheme_ff <= nxt_scheme;
            filterMs_ff <= nxt_filterMs;
            onMs_ff <= nxt_onMs;
            offMs_ff <= nxt_offMs;
            wrPend_ff <= nxt_wrPend;
            wrAddr_ff <= nxt_wrAddr;
            rdata_ff <= nxt_rdata;
        end
    end

    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Per-terminal conditioning chain.
    logic [8:0] rawPins;
    // Inputs five to eight have no pin and read as open unless made virtual.
    assign rawPins = {highSpeedInput, 4'h0, generalInputsOneToFour};

    for (genvar g = 0; g < N; g++) begin : gTerm
        logic lvl_ff, nxt_lvl, filt_ff, nxt_filt, out_ff, nxt_out;
        logic [CW-1:0] fcnt_ff, nxt_fcnt, dcnt_ff, nxt_dcnt;
        logic [CW-1:0] fLimit, dLimit;
        assign fLimit = CW'(filterMs_ff) * CW'(MS_CYC);
        assign dLimit = CW'(filt_ff ? onMs_ff[g] : offMs_ff[g]) * CW'(MS_CYC);
        always_comb begin
            // Polarity applied first, then the virtual state replaces the pin.
            nxt_lvl = virtSel_ff[g] ? virtState_ff[g] : (rawPins[g] ^ polarity_ff[g]);
            nxt_filt = filt_ff;
            nxt_fcnt = '0;
            // A level must hold unchanged for the filter time before it is accepted.
            if (lvl_ff != filt_ff) begin
                if (fcnt_ff >= fLimit) begin
                    nxt_filt = lvl_ff;
                end else begin
                    nxt_fcnt = fcnt_ff + 1'b1;
                end
            end
            nxt_out = out_ff;
            nxt_dcnt = '0;
            // Reported change waits for the on or off delay; a bounce restarts it.
            if (filt_ff != out_ff) begin
                if (dcnt_ff >= dLimit) begin
                    nxt_out = filt_ff;
                end else begin
                    nxt_dcnt = dcnt_ff + 1'b1;
                end
            end
        end
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                lvl_ff <= 1'b0;
                filt_ff <= 1'b0;
                out_ff <= 1'b0;
                fcnt_ff <= '0;
                dcnt_ff <= '0;
            end else begin
                lvl_ff <= nxt_lvl;
                filt_ff <= nxt_filt;
                out_ff <= nxt_out;
                fcnt_ff <= nxt_fcnt;
                dcnt_ff <= nxt_dcnt;
            end
        end
        assign filtered[g] = filt_ff;
        assign cond_ff[g] = out_ff;
    end

    assign terminalState = cond_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Run command decode.
    logic fwdPrev_ff, bwdPrev_ff;
    logic forward_run_input, bwd, en3;
    assign forward_run_input = cond_ff[ditc_pkg::FWD_IDX];
    assign bwd = cond_ff[ditc_pkg::BWD_IDX];
    assign en3 = cond_ff[ditc_pkg::EN3_IDX];

    // Two-wire schemes are combinational on the levels; three-wire holds state.
    always_comb begin
        nxt_cmd = cmd_ff;
        case (scheme_ff)
            ditc_pkg::SCH_TWO_COMB: begin
                nxt_cmd.run = forward_run_input ^ bwd;
                nxt_cmd.reverse = bwd && !forward_run_input;
            end
            ditc_pkg::SCH_TWO_SPLIT: begin
                nxt_cmd.run = forward_run_input;
                nxt_cmd.reverse = bwd;
            end
            default: begin
                if (!en3) begin
                    nxt_cmd.run = 1'b0;
                end else if (cmd_ff.run && bwd != bwdPrev_ff) begin
                    nxt_cmd.reverse = !cmd_ff.reverse;
                end else if (!cmd_ff.run && forward_run_input && !fwdPrev_ff) begin
                    nxt_cmd.run = 1'b1;
                    nxt_cmd.reverse = bwd;
                end
            end
        endcase
    end

    // Command state and edge history.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_ff <= '0;
            fwdPrev_ff <= 1'b0;
            bwdPrev_ff <= 1'b0;
        end else begin
            cmd_ff <= nxt_cmd;
            fwdPrev_ff <= forward_run_input;
            bwdPrev_ff <= bwd;
        end
    end

    assign runCmd = cmd_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    chk_pol_reset: assert property (@(posedge core_clk) $rose(reset_n) |-> polarity_ff == 9'h000)
        else $error("polarity mask not zero after reset");
    chk_filter_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        gTerm[3].lvl_ff != filtered[3] && gTerm[3].fcnt_ff < gTerm[3].fLimit |=> $stable(filtered[3]))
        else $error("filter passed a level too early");
    chk_virt_subst: assert property (@(posedge core_clk) disable iff (!reset_n)
        (virtSel_ff[4] && $stable(virtSel_ff[4])) |=> gTerm[4].lvl_ff == $past(virtState_ff[4]))
        else $error("virtual state not substituted");
    chk_nopin_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
        (virtSel_ff[7:4] == 4'h0) |=> gTerm[4].lvl_ff == $past(polarity_ff[4]))
        else $error("pinless input saw a level");
    chk_scheme0_dir: assert property (@(posedge core_clk) disable iff (!reset_n)
        scheme_ff == 2'h0 && forward_run_input && !bwd |=> cmd_ff.run && !cmd_ff.reverse)
        else $error("two-wire forward decode wrong");
    chk_scheme0_stop: assert property (@(posedge core_clk) disable iff (!reset_n)
        scheme_ff == 2'h0 && !forward_run_input && !bwd |=> !cmd_ff.run)
        else $error("two-wire stop decode wrong");
    chk_scheme1_en: assert property (@(posedge core_clk) disable iff (!reset_n)
        scheme_ff == 2'h1 |=> cmd_ff.run == $past(forward_run_input) && cmd_ff.reverse == $past(bwd))
        else $error("split two-wire decode wrong");
    chk_three_start: assert property (@(posedge core_clk) disable iff (!reset_n)
        scheme_ff[1] && en3 && !cmd_ff.run && forward_run_input && !fwdPrev_ff |=> cmd_ff.run && cmd_ff.reverse == $past(bwd))
        else $error("three-wire start wrong");
    chk_three_stop: assert property (@(posedge core_clk) disable iff (!reset_n)
        scheme_ff[1] && !en3 |=> !cmd_ff.run)
        else $error("three-wire enable open did not stop");
    chk_three_rev: assert property (@(posedge core_clk) disable iff (!reset_n)
        scheme_ff[1] && en3 && cmd_ff.run && bwd != bwdPrev_ff |=> cmd_ff.reverse != $past(cmd_ff.reverse))
        else $error("three-wire reversal missing");
    chk_delay_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        onMs_ff[0] == 16'h0000 && filtered[0] && !cond_ff[0] |=> cond_ff[0])
        else $error("zero on delay not immediate");
    cov_fwd_run: cover property (@(posedge core_clk) disable iff (!reset_n) cmd_ff.run && !cmd_ff.reverse);
    cov_rev_run: cover property (@(posedge core_clk) disable iff (!reset_n) cmd_ff.run && cmd_ff.reverse);
    cov_three_rev: cover property (@(posedge core_clk) disable iff (!reset_n) scheme_ff[1] && $changed(cmd_ff.reverse));
    cov_virtual: cover property (@(posedge core_clk) disable iff (!reset_n) virtSel_ff != 9'h000);
endmodule : ditc_conditioner

// [test/ditc_switch_model.sv]
// Behavioural contact bank on the physical terminals: general inputs one to four and the high-speed input.
// Assumes the bench sets the wanted levels by non-blocking assignment just after a rising core_clk edge.
`timescale 1ns/1ns
module ditc_switch_model (
    // Clock.
    input wire logic core_clk,
    // Wanted contact levels (bit 4 is the high-speed input) and chatter length in cycles.
    input wire logic [4:0] wantLevel,
    input wire logic [3:0] bounceLen,
    // Terminal lines.
    output logic [3:0] generalInputsOneToFour,
    output logic highSpeedInput
);
    logic [4:0] lastLevel_ff = 5'h00;
    logic [4:0] moved_ff = 5'h00;
    logic [3:0] bounceCnt_ff = 4'h0;
    logic [4:0] line_ff = 5'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // A contact that moves chatters for bounceLen cycles before it settles.
    always_ff @(posedge core_clk) begin
        if (wantLevel != lastLevel_ff) begin
            bounceCnt_ff <= bounceLen;
            moved_ff <= wantLevel ^ lastLevel_ff;
        end else if (bounceCnt_ff != 4'h0) begin
            bounceCnt_ff <= bounceCnt_ff - 4'h1;
        end
        lastLevel_ff <= wantLevel;
        line_ff <= wantLevel ^ (bounceCnt_ff[0] ? moved_ff : 5'h00);
    end

    // Once its chatter has ended, the enable contact stays closed for as long as the bench holds it; it chatters open like any other contact that moves.
    assign generalInputsOneToFour = line_ff[3:0];
    assign highSpeedInput = line_ff[4];
endmodule : ditc_switch_model

// [test/tb.sv]
// Self-checking bench for the input terminal conditioner with a contact model on its pins.
// Assumes the conditioner is built with a short millisecond of MS cycles.
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    localparam int MS = 4;
    typedef struct packed {logic [1:0] sch; logic [4:0] pins; logic [1:0] cmd;} ditc_row_t;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [31:0] hwdata = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hrdata;
    logic [31:0] rdata;
    logic hreadyout;
    logic hresp;
    wire hready = hreadyout;
    logic [4:0] wantLevel = 5'h00;
    logic [3:0] bounceLen = 4'h0;
    logic [3:0] pinsGen;
    logic pinHs;
    logic [8:0] terminalState;
    ditc_pkg::ditc_cmd_t runCmd;
    int err_count = 0;
    int check_count = 0;
    // Scheme, pin levels (bit 2 enable, 1 backward, 0 forward) and expected {run, reverse while running}.
    ditc_row_t rows[20] = '{
        {2'h0, 5'h00, 2'h0}, {2'h0, 5'h01, 2'h2}, {2'h0, 5'h02, 2'h3}, {2'h0, 5'h03, 2'h0},
        {2'h1, 5'h01, 2'h2}, {2'h1, 5'h03, 2'h3}, {2'h1, 5'h02, 2'h0}, {2'h1, 5'h00, 2'h0},
        {2'h2, 5'h04, 2'h0}, {2'h2, 5'h06, 2'h0}, {2'h2, 5'h07, 2'h3}, {2'h2, 5'h05, 2'h2},
        {2'h2, 5'h07, 2'h3}, {2'h2, 5'h03, 2'h0}, {2'h2, 5'h07, 2'h0}, {2'h3, 5'h04, 2'h0},
        {2'h3, 5'h05, 2'h2}, {2'h3, 5'h15, 2'h2}, {2'h3, 5'h01, 2'h0}, {2'h0, 5'h00, 2'h0}};

    ditc_conditioner #(.MS_CYC(MS)) ditc_conditioner_inst (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .generalInputsOneToFour(pinsGen),
        .highSpeedInput(pinHs), .terminalState(terminalState), .runCmd(runCmd));
    ditc_switch_model ditc_switch_model_inst (.core_clk(core_clk), .wantLevel(wantLevel), .bounceLen(bounceLen),
        .generalInputsOneToFour(pinsGen), .highSpeedInput(pinHs));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and a guard against a hang.
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #900000;
        err_count++;
        wrap_up();
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Waits a bounded number of edges for hready.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            wrap_up();
        end
    endtask : wait_ready

    // One single word transfer; read data lands in rdata.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdata = hrdata;
    endtask : bus

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        `CHK({terminalState, runCmd}, 11'h000)
        bus(1'b0, ditc_pkg::OFS_POLARITY, 32'h0);
        `CHK(rdata, 32'h00000000)
        bus(1'b0, ditc_pkg::OFS_FILTER, 32'h0);
        `CHK(rdata, 32'h0000000A)
        bus(1'b0, ditc_pkg::OFS_VIRTUAL, 32'h0);
        `CHK(rdata, 32'h00000000)
        bus(1'b0, ditc_pkg::OFS_SCHEME, 32'h0);
        `CHK(rdata, 32'h00000000)
        bus(1'b1, 8'h30, 32'hFFFFFFFF);
        bus(1'b0, 8'h30, 32'h0);
        `CHK(rdata, 32'h00000000)
        // Command decode in every scheme with the filter off.
        bus(1'b1, ditc_pkg::OFS_FILTER, 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, ditc_pkg::OFS_SCHEME, {30'h0, rows[i].sch});
            wantLevel <= rows[i].pins;
            repeat (8) @(posedge core_clk);
            `CHK({runCmd.run, runCmd.run & runCmd.reverse}, rows[i].cmd)
            `CHK(terminalState, {rows[i].pins[4], 4'h0, rows[i].pins[3:0]})
            bus(1'b0, ditc_pkg::OFS_STATUS, 32'h0);
            `CHK({rdata[9], rdata[9] & rdata[10], rdata[8:0]}, {rows[i].cmd, rows[i].pins[4], 4'h0, rows[i].pins[3:0]})
        end
        // Inverted polarity on every terminal, with terminal one held high.
        bus(1'b1, ditc_pkg::OFS_POLARITY, 32'h000001FF);
        wantLevel <= 5'h01;
        bus(1'b0, ditc_pkg::OFS_POLARITY, 32'h0);
        `CHK(rdata, 32'h000001FF)
        repeat (8) @(posedge core_clk);
        `CHK(terminalState, 9'h1FE)
        bus(1'b1, ditc_pkg::OFS_POLARITY, 32'h0);
        // Virtual levels replace only selected terminals; pinless ones stay low unless selected.
        bus(1'b1, ditc_pkg::OFS_VSTATE, 32'h000000F0);
        wantLevel <= 5'h1F;
        repeat (8) @(posedge core_clk);
        `CHK(terminalState, 9'h10F)
        bus(1'b1, ditc_pkg::OFS_VIRTUAL, 32'h000001F0);
        repeat (8) @(posedge core_clk);
        `CHK(terminalState, 9'h0FF)
        bus(1'b1, ditc_pkg::OFS_VIRTUAL, 32'h0);
        wantLevel <= 5'h00;
        // Let every terminal settle low before the filter is lengthened.
        repeat (8) @(posedge core_clk);
        // A chattering contact is hidden by a 2 ms filter until it settles.
        bus(1'b1, ditc_pkg::OFS_FILTER, 32'h00000002);
        bounceLen <= 4'h4;
        wantLevel <= 5'h08;
        repeat (10) @(posedge core_clk);
        `CHK(terminalState, 9'h000)
        repeat (20) @(posedge core_clk);
        `CHK(terminalState, 9'h008)
        bus(1'b1, ditc_pkg::OFS_FILTER, 32'h0000FFFF);
        bus(1'b0, ditc_pkg::OFS_FILTER, 32'h0);
        `CHK(rdata[15:0], ditc_pkg::TIME_MS_MAX)
        // On delay 3 ms and off delay 1 ms on terminal four.
        bus(1'b1, ditc_pkg::OFS_FILTER, 32'h0);
        bounceLen <= 4'h0;
        wantLevel <= 5'h00;
        bus(1'b1, 8'h58, 32'h00000003);
        bus(1'b1, 8'h5C, 32'h00000001);
        repeat (8) @(posedge core_clk);
        wantLevel <= 5'h08;
        repeat (8) @(posedge core_clk);
        `CHK(terminalState, 9'h000)
        repeat (20) @(posedge core_clk);
        `CHK(terminalState, 9'h008)
        wantLevel <= 5'h00;
        repeat (4) @(posedge core_clk);
        `CHK(terminalState, 9'h008)
        repeat (12) @(posedge core_clk);
        `CHK(terminalState, 9'h000)
        bus(1'b1, 8'h58, 32'h0000FFFF);
        bus(1'b0, 8'h58, 32'h0);
        `CHK(rdata[15:0], ditc_pkg::TIME_MS_MAX)
        // A reset in mid-run restores every register and clears the outputs.
        bus(1'b1, ditc_pkg::OFS_POLARITY, 32'h000001FF);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        `CHK({terminalState, runCmd}, 11'h000)
        bus(1'b0, ditc_pkg::OFS_POLARITY, 32'h0);
        `CHK(rdata, 32'h00000000)
        bus(1'b0, 8'h58, 32'h0);
        `CHK(rdata, 32'h00000000)
        wrap_up();
    end
endmodule : tb
